// ===== logic/seh_defs.svh
// Purpose: constants shared by both ends of the host command link
// Assumes: 25 MHz core clock
// Notes:   definitions only
`ifndef SEH_DEFS_SVH
`define SEH_DEFS_SVH
// ----------------------------------------
// link addresses and command codes
// ----------------------------------------
`define SEH_ADDR_WR   8'h80
`define SEH_ADDR_RD   8'h81
`define SEH_CMD_BYP   8'h01
`define SEH_CMD_INTEL 8'h02
`define SEH_CMD_EQ    8'h03
`define SEH_CMD_LEVEL 8'h04
`define SEH_CMD_FLAT  8'h05
`define SEH_CMD_PRE1  8'h06
`define SEH_CMD_PRE2  8'h07
`define SEH_CMD_PRE3  8'h08
`define SEH_CMD_PRE4  8'h09
`define SEH_CMD_TONE  8'h0A
`define SEH_CMD_FILT  8'h0B
`define SEH_CMD_TEST  8'h0C
`define SEH_CMD_THR   8'h0D
`define SEH_CMD_QUERY 8'h0E
`define SEH_Q_STATUS  8'h01
`define SEH_Q_BAND1   8'h02
`define SEH_Q_BAND4   8'h05
// ----------------------------------------
// field limits and reset values
// ----------------------------------------
`define SEH_GAIN_MAX  5'h18
`define SEH_GAIN_0DB  5'h0C
`define SEH_B1_RST    5'h10
`define SEH_B2_RST    5'h0C
`define SEH_B3_RST    5'h0C
`define SEH_B4_RST    5'h0D
`define SEH_FILT_MAX  4'hC
`define SEH_FILT_RST  4'hC
`define SEH_FILT_LAST 4'h9
`define SEH_LEVEL_RST 2'h1
`define SEH_LEVEL_MAX 8'h02
`define SEH_THR_RST   8'h1F
`define SEH_STAT_RST  8'h05
// ----------------------------------------
// timing
// ----------------------------------------
`define SEH_CLK_MHZ   25
`define SEH_QUIET_MS  25
`define SEH_QUIET_CYC (`SEH_QUIET_MS * `SEH_CLK_MHZ * 1000)
`define SEH_SCL_QTR   4'h8
// ----------------------------------------
// host register map
// ----------------------------------------
`define SEH_REG_CMD   4'h0
`define SEH_REG_STAT  4'h4
`define SEH_F_WDATA   16
`define SEH_F_READ    17
`endif

// ===== logic/seh_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   numbers live in seh_defs.svh
`default_nettype none
package seh_pkg;
   typedef enum logic [2:0] {
      SD_IDLE = 3'h0, SD_ADDR = 3'h1, SD_ACK = 3'h3,
      SD_WR   = 3'h2, SD_TX   = 3'h6, SD_RACK = 3'h7
   } seh_dev_e;
   typedef enum logic [1:0] {
      SH_IDLE = 2'h0, SH_START = 2'h1, SH_BITS = 2'h3, SH_STOP = 2'h2
   } seh_host_e;
   typedef logic [4:0] seh_gain_t;
   typedef logic [3:0] seh_fgain_t;
endpackage : seh_pkg
`default_nettype wire

// ===== logic/seh_if.sv
// Purpose: two-wire link between controller and device
// Assumes: open drain lines with pull-ups
// Notes:   an enable high pulls its line low
`timescale 1ns/1ps
`default_nettype none
interface seh_if;
   logic scl_o;
   logic scl_oe;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;
   // pull-up wins unless someone drives low
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
   modport host (output scl_o, scl_oe, h_sda_o, h_sda_oe, input scl, sda);
   modport dev  (output d_sda_o, d_sda_oe, input scl, sda);
endinterface : seh_if
`default_nettype wire

// ===== logic/seh_pinsync.sv
// Purpose: synchronise link pins and find edges, start and stop
// Assumes: pins asynchronous to CLK
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module seh_pinsync (
   input  wire logic CLK,      // core clock
   input  wire logic RST_B,    // async reset, low
   input  wire logic scl,      // clock pin
   input  wire logic sda,      // data pin
   output logic      scl_s,    // synced clock
   output logic      sda_s,    // synced data
   output logic      scl_rise, // clock rose
   output logic      scl_fall, // clock fell
   output logic      start,    // start seen
   output logic      stop      // stop seen
);
   logic [2:0] sc;
   logic [2:0] sd;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sc <= 3'h7;
         sd <= 3'h7;
      end else begin
         sc <= {sc[1:0], scl};
         sd <= {sd[1:0], sda};
      end
   end

   assign scl_s    = sc[1];
   assign sda_s    = sd[1];
   assign scl_rise = sc[1] & ~sc[2];
   assign scl_fall = ~sc[1] & sc[2];
   assign start    = sc[1] & sc[2] & ~sd[1] & sd[2];
   assign stop     = sc[1] & sc[2] & sd[1] & ~sd[2];
endmodule : seh_pinsync
`default_nettype wire

// ===== logic/seh_device.sv
// Purpose: speech enhancer command slave on the two-wire link
// Assumes: core logic and samples on CLK; link pins asynchronous
// Notes:   stores mode, gains and threshold; signal path outside
`timescale 1ns/1ps
`include "seh_defs.svh"
`default_nettype none
// Functional notes
// - master starts only on idle bus
// - data changes only while clock low
// - start and stop detected on data edges
// - eight bit bytes, msb first, address first
// - receiver pulls ack low on ninth pulse
// - transmitter releases data during ack
// - master nacks the byte it reads
// - write address 80, read address 81
// - 01 bypass, processor stopped, reset default
// - 02 selects intelligibility mode
// - 03 equalizer mode, default band gains; code leaves the band gains as they are
// - level command 04 only in intelligibility
// - 05 flat, 06 to 09 presets
// - 0A sets one band gain
// - 0B sets one of ten filter gains
// - test byte echo moved to 0C
// - 0D stores noise threshold, reset 1F
// - quiet input for 25 ms reads zero
// - 0E 01 readies status byte
// - 0E 02 to 05 ready band gains
module seh_device #(
   parameter int QUIET_CYC = `SEH_QUIET_CYC
) (
   input  wire logic               CLK,          // core clock
   input  wire logic               RST_B,        // async reset, low
   seh_if.dev                      LINK,         // two-wire link
   input  wire logic               PCM_DIN,      // pcm serial in pin
   input  wire logic               DSP_DOUT,     // processed serial out
   input  wire logic [15:0]        SAMPLE,       // input sample
   input  wire logic               SAMPLE_VALID, // sample strobe
   output logic                    PCM_DOUT,     // pcm serial out
   output logic                    DSP_HALT,     // processor stopped
   output logic                    MODE_EQ,      // equalizer mode
   output logic [1:0]              LEVEL,        // intelligibility level
   output seh_pkg::seh_gain_t [3:0]  BAND_GAIN,  // 0=-12 dB .. 18=+12
   output seh_pkg::seh_fgain_t [9:0] FILT_GAIN,  // 0=+12 dB .. C=0 dB
   output logic [7:0]              NOISE_THR,    // noise threshold
   output logic                    INPUT_ZERO,   // input treated as zero
   output logic [7:0]              STATUS        // current status
);
   import seh_pkg::*;

   localparam seh_gain_t BAND_RST [4] = '{`SEH_B1_RST, `SEH_B2_RST,
                                        `SEH_B3_RST, `SEH_B4_RST};

   seh_dev_e   st;
   logic       scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
   logic [3:0] cnt;
   logic [7:0] sh;
   logic [7:0] cmd;
   logic [7:0] tx;
   logic       first, rd, drive;
   logic       byte_ok, cmd_ev, dat_ev;
   logic       bypass, eq;
   logic [1:0] level;
   logic [7:0] thr;
   logic [1:0] din_s;
   logic [19:0] qcnt;
   logic [15:0] mag;
   logic       zero;
   seh_gain_t  gain [4];
   seh_fgain_t fgain [10];

   function automatic seh_gain_t preset(input logic [7:0] c,
                                        input logic [1:0] b);
      logic [19:0] p;
      p = {4{`SEH_GAIN_0DB}};
      case (c)
         `SEH_CMD_PRE1: p = {5'h0D, 5'h0B, 5'h0B, 5'h0F};
         `SEH_CMD_PRE2: p = {5'h0F, 5'h0C, 5'h0C, 5'h0F};
         `SEH_CMD_PRE3: p = {5'h0C, 5'h0C, 5'h0C, 5'h11};
         `SEH_CMD_PRE4: p = {5'h0D, 5'h0C, 5'h0C, 5'h11};
         default: ;
      endcase
      return p[5'(b) * 5'h5 +: 5];
   endfunction : preset

   // ----------------------------------------
   // link receive and transmit
   // ----------------------------------------
   // pin edges decoded
   seh_pinsync u_sync (
      .CLK      (CLK),
      .RST_B    (RST_B),
      .scl      (LINK.scl),
      .sda      (LINK.sda),
      .scl_s    (scl_s),
      .sda_s    (sda_s),
      .scl_rise (scl_rise),
      .scl_fall (scl_fall),
      .start    (start_c),
      .stop     (stop_c)
   );

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st    <= SD_IDLE;
         cnt   <= 4'h0;
         sh    <= 8'h00;
         first <= 1'h0;
         rd    <= 1'h0;
         drive <= 1'h0;
      end else if (start_c) begin
         st    <= SD_ADDR;
         cnt   <= 4'h0;
         first <= 1'h1;
         drive <= 1'h0;
      end else if (stop_c) begin
         st    <= SD_IDLE;
         drive <= 1'h0;
      end else begin
         case (st)
            SD_ADDR, SD_WR: begin
               if (scl_rise) begin
                  sh  <= {sh[6:0], sda_s};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  if (st == SD_WR) begin
                     drive <= 1'h1;
                     first <= 1'h0;
                     st    <= SD_ACK;
                  end else if (sh == `SEH_ADDR_WR || sh == `SEH_ADDR_RD) begin
                     drive <= 1'h1;
                     rd    <= sh[0];
                     st    <= SD_ACK;
                  end else begin
                     st <= SD_IDLE;
                  end
               end
            end
            SD_ACK: begin
               if (scl_fall) begin
                  cnt <= 4'h0;
                  if (rd) begin
                     drive <= ~tx[7];
                     st    <= SD_TX;
                  end else begin
                     drive <= 1'h0;
                     st    <= SD_WR;
                  end
               end
            end
            SD_TX: begin
               if (scl_rise) begin
                  cnt <= cnt + 4'h1;
               end else if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     drive <= 1'h0;
                     st    <= SD_RACK;
                  end else begin
                     drive <= ~tx[3'(4'h7 - cnt)];
                  end
               end
            end
            SD_RACK: begin
               if (scl_rise) begin
                  st <= sda_s ? SD_IDLE : SD_ACK;
               end
            end
            default: st <= SD_IDLE;
         endcase
      end
   end

   assign LINK.d_sda_o  = 1'h0;
   assign LINK.d_sda_oe = drive;

   assign byte_ok = (st == SD_WR) && scl_fall && (cnt == 4'h8) &&
                    !start_c && !stop_c;
   assign cmd_ev  = byte_ok & first;
   assign dat_ev  = byte_ok & ~first;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmd <= 8'h00;
      end else if (cmd_ev) begin
         cmd <= sh;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         bypass <= 1'h1;
         eq     <= 1'h0;
         level  <= `SEH_LEVEL_RST;
      end else if (cmd_ev) begin
         case (sh)
            `SEH_CMD_BYP: bypass <= 1'h1;
            `SEH_CMD_INTEL: begin
               bypass <= 1'h0;
               eq     <= 1'h0;
            end
            `SEH_CMD_EQ: begin
               bypass <= 1'h0;
               eq     <= 1'h1;
            end
            default: ;
         endcase
      end else if (dat_ev && cmd == `SEH_CMD_LEVEL && !bypass && !eq &&
                   sh <= `SEH_LEVEL_MAX) begin
         level <= sh[1:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         thr <= `SEH_THR_RST;
      end else if (dat_ev && cmd == `SEH_CMD_THR) begin
         thr <= sh;
      end
   end

   for (genvar b = 0; b < 4; b++) begin : g_band
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            gain[b] <= BAND_RST[b];
         end else if (cmd_ev && sh >= `SEH_CMD_FLAT &&
                      sh <= `SEH_CMD_PRE4) begin
            gain[b] <= preset(sh, 2'(b));
         end else if (dat_ev && cmd == `SEH_CMD_TONE &&
                      sh[7:5] == 3'(b) && sh[4:0] <= `SEH_GAIN_MAX) begin
            gain[b] <= `SEH_GAIN_MAX - sh[4:0];
         end
      end
      assign BAND_GAIN[b] = gain[b];
   end

   for (genvar f = 0; f < 10; f++) begin : g_filt
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            fgain[f] <= `SEH_FILT_RST;
         end else if (dat_ev && cmd == `SEH_CMD_FILT &&
                      sh[7:4] == 4'(f) && sh[3:0] <= `SEH_FILT_MAX) begin
            fgain[f] <= sh[3:0];
         end
      end
      assign FILT_GAIN[f] = fgain[f];
   end

   // ----------------------------------------
   // response byte
   // ----------------------------------------
   // held until next request
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx <= 8'h00;
      end else if (dat_ev) begin
         if (cmd == `SEH_CMD_TEST) begin
            tx <= sh;
         end else if (cmd == `SEH_CMD_QUERY) begin
            if (sh == `SEH_Q_STATUS) begin
               tx <= {4'h0, level, eq, bypass};
            end else if (sh >= `SEH_Q_BAND1 && sh <= `SEH_Q_BAND4) begin
               tx <= {3'h0, gain[2'(sh - `SEH_Q_BAND1)]};
            end
         end
      end
   end

   // ----------------------------------------
   // pcm path and noise gate
   // ----------------------------------------
   always_comb begin
      mag = SAMPLE[15] ? 16'(-SAMPLE) : SAMPLE;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         qcnt <= 20'h00000;
         zero <= 1'h0;
      end else if (SAMPLE_VALID && mag >= {8'h00, thr}) begin
         qcnt <= 20'h00000;
         zero <= 1'h0;
      end else if (qcnt == 20'(QUIET_CYC - 1)) begin
         zero <= 1'h1;
      end else begin
         qcnt <= qcnt + 20'h00001;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         din_s    <= 2'h0;
         PCM_DOUT <= 1'h0;
         STATUS   <= `SEH_STAT_RST;
      end else begin
         din_s    <= {din_s[0], PCM_DIN};
         PCM_DOUT <= bypass ? din_s[1] : DSP_DOUT;
         STATUS   <= {4'h0, level, eq, bypass};
      end
   end

   assign DSP_HALT   = bypass;
   assign MODE_EQ    = eq;
   assign LEVEL      = level;
   assign NOISE_THR  = thr;
   assign INPUT_ZERO = zero;
endmodule : seh_device
`default_nettype wire

// ===== logic/seh_host.sv
// Purpose: link master taking orders over classic wishbone
// Assumes: device answers with open-drain ack
// Notes:   one transfer at a time; write while busy is dropped
`timescale 1ns/1ps
`include "seh_defs.svh"
`default_nettype none
module seh_host (
   input  wire logic        CLK,      // core clock
   input  wire logic        RST_B,    // async reset, low
   seh_if.host              LINK,     // two-wire link
   input  wire logic        WB_CYC_I, // bus cycle
   input  wire logic        WB_STB_I, // strobe
   input  wire logic        WB_WE_I,  // write
   input  wire logic [3:0]  WB_ADR_I, // byte address
   input  wire logic [31:0] WB_DAT_I, // write data
   input  wire logic [3:0]  WB_SEL_I, // byte lanes
   output logic      [31:0] WB_DAT_O, // read data
   output logic             WB_ACK_O, // acknowledge
   output logic             BUSY      // transfer pending
);
   import seh_pkg::*;

   seh_host_e  st;
   logic       scl_s, sda_s;
   logic [3:0] div;
   logic       tick;
   logic [1:0] ph;
   logic [3:0] bitn;
   logic [1:0] bi, nb;
   logic       rdop, rdb, go;
   logic [7:0] sh, cmd_b, dat_b, rdata;
   logic       nack, scl_dn, sda_dn;

   seh_pinsync u_sync (
      .CLK      (CLK),
      .RST_B    (RST_B),
      .scl      (LINK.scl),
      .sda      (LINK.sda),
      .scl_s    (scl_s),
      .sda_s    (sda_s),
      .scl_rise (),
      .scl_fall (),
      .start    (),
      .stop     ()
   );

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   assign go = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] &&
               WB_ADR_I == `SEH_REG_CMD && !BUSY;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         WB_ACK_O <= 1'h0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
         WB_DAT_O <= (WB_ADR_I == `SEH_REG_STAT) ?
                     {16'h0000, rdata, 6'h00, nack, BUSY} : 32'h00000000;
      end
   end

   // ----------------------------------------
   // link master
   // ----------------------------------------
   assign tick = (div == `SEH_SCL_QTR - 4'h1);
   assign rdb  = rdop && (bi == 2'h1);

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         div <= 4'h0;
      end else begin
         div <= (st == SH_IDLE || tick) ? 4'h0 : div + 4'h1;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st     <= SH_IDLE;
         ph     <= 2'h0;
         bitn   <= 4'h0;
         bi     <= 2'h0;
         nb     <= 2'h0;
         rdop   <= 1'h0;
         sh     <= 8'h00;
         cmd_b  <= 8'h00;
         dat_b  <= 8'h00;
         rdata  <= 8'h00;
         nack   <= 1'h0;
         BUSY   <= 1'h0;
         scl_dn <= 1'h0;
         sda_dn <= 1'h0;
      end else begin
         case (st)
            SH_IDLE: begin
               ph <= 2'h0;
               if (go) begin
                  BUSY  <= 1'h1;
                  nack  <= 1'h0;
                  bi    <= 2'h0;
                  cmd_b <= WB_DAT_I[7:0];
                  dat_b <= WB_DAT_I[15:8];
                  rdop  <= WB_DAT_I[`SEH_F_READ];
                  nb    <= (WB_DAT_I[`SEH_F_READ] || !WB_DAT_I[`SEH_F_WDATA]) ?
                           2'h2 : 2'h3;
                  sh    <= WB_DAT_I[`SEH_F_READ] ? `SEH_ADDR_RD : `SEH_ADDR_WR;
               end else if (BUSY && scl_s && sda_s) begin
                  st <= SH_START;
               end
            end
            SH_START: if (tick) begin
               ph <= ph + 2'h1;
               // start, data falls while clock high
               if (ph == 2'h1) begin
                  sda_dn <= 1'h1;
               end else if (ph == 2'h3) begin
                  scl_dn <= 1'h1;
                  bitn   <= 4'h0;
                  st     <= SH_BITS;
               end
            end
            SH_BITS: if (tick) begin
               ph <= ph + 2'h1;
               case (ph)
                  2'h0: sda_dn <= !(bitn == 4'h8 || rdb) && !sh[7];
                  2'h1: scl_dn <= 1'h0;
                  2'h2: begin
                     if (bitn != 4'h8) begin
                        sh <= {sh[6:0], sda_s};
                     end else if (!rdb) begin
                        nack <= sda_s;
                     end
                  end
                  default: begin
                     scl_dn <= 1'h1;
                     if (bitn != 4'h8) begin
                        bitn <= bitn + 4'h1;
                     end else if (rdb || nack || bi == nb - 2'h1) begin
                        if (rdb) begin
                           rdata <= sh;
                        end
                        st <= SH_STOP;
                     end else begin
                        bi   <= bi + 2'h1;
                        sh   <= (bi == 2'h0) ? cmd_b : dat_b;
                        bitn <= 4'h0;
                     end
                  end
               endcase
            end
            SH_STOP: if (tick) begin
               ph <= ph + 2'h1;
               // stop, data rises while clock high
               case (ph)
                  2'h0: sda_dn <= 1'h1;
                  2'h1: scl_dn <= 1'h0;
                  2'h2: sda_dn <= 1'h0;
                  default: begin
                     BUSY <= 1'h0;
                     st   <= SH_IDLE;
                  end
               endcase
            end
            default: st <= SH_IDLE;
         endcase
      end
   end

   assign LINK.scl_o    = 1'h0;
   assign LINK.scl_oe   = scl_dn;
   assign LINK.h_sda_o  = 1'h0;
   assign LINK.h_sda_oe = sda_dn;
endmodule : seh_host
`default_nettype wire

// ===== sim/seh_chk.sv
// Purpose: link protocol checks
// Assumes: wires sampled on CLK
// Notes:   sees the shared interface only
`timescale 1ns/1ps
`default_nettype none
module seh_chk (
   input  wire logic CLK,      // core clock
   input  wire logic RST_B,    // async reset, low
   input  wire logic scl_oe,   // host pulls clock
   input  wire logic h_sda_oe, // host pulls data
   input  wire logic d_sda_oe, // device pulls data
   input  wire logic scl,      // clock wire
   input  wire logic sda       // data wire
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   logic [7:0] n_rise;
   // --------
   // clock pulses since start
   // --------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B)
         n_rise <= 8'h00;
      else if ($fell(sda) && scl)
         n_rise <= 8'h00;
      else if ($rose(scl))
         n_rise <= n_rise + 8'h01;
   end
   a_dev_data_low: assert property ($changed(d_sda_oe) |-> !scl)
      else $error("device data moved with clock high");
   a_host_one_pin: assert property (!($changed(scl_oe) && $changed(h_sda_oe)))
      else $error("host moved both lines at once");
   a_ack_holds: assert property ($rose(scl) && d_sda_oe |-> d_sda_oe[*8])
      else $error("device data dropped in high phase");
   a_ack_host_free: assert property ($rose(scl) && d_sda_oe |-> !h_sda_oe)
      else $error("host holds data during device bit");
   a_start_clk: assert property ($fell(sda) && scl |-> ##[1:24] !scl)
      else $error("no clock after start");
   a_stop_idle: assert property ($rose(sda) && scl |=> (sda && scl)[*8])
      else $error("bus not idle after stop");
   a_nine_bits: assert property ($rose(sda) && scl |-> n_rise % 8'h09 == 8'h01)
      else $error("frame not whole bytes");
   a_ack_setup: assert property ($rose(d_sda_oe) |-> !scl[*6] ##[1:12] scl)
      else $error("device bit not set up before clock");
   c_start: cover property ($fell(sda) && scl);
   c_dev_bit: cover property ($rose(scl) && d_sda_oe);
   c_stop: cover property ($rose(sda) && scl);
endmodule : seh_chk
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: drive host commands, check device state
// Assumes: host and device joined by seh_if
// Notes:   quiet span cut to 50 cycles
`timescale 1ns/1ps
`include "seh_defs.svh"
`default_nettype none
module testbench;
   import seh_pkg::*;
   logic                CLK, RST_B, cyc, stb, we, ack, sv, halt, izero;
   logic                pin, dout, meq, busy;
   logic [1:0]          lvl;
   logic [3:0]          adr;
   logic [7:0]          stat, thr;
   logic [15:0]         smp;
   logic [31:0]         dw, dr, q;
   seh_gain_t  [3:0]    band;
   seh_fgain_t [9:0]    filt;
   int                  errors, n_compared;
   logic [31:0] w [17] = '{32'h2, 32'h10004, 32'h10304, 32'h3, 32'h10204,
      32'h5, 32'h6, 32'h7, 32'h8, 32'h9, 32'h1600A, 32'h1180A, 32'h1190A,
      32'h1000D, 32'hF, 32'h2, 32'h1};
   logic [31:0] e [17] = '{32'h04100D1F, 32'h00100D1F, 32'h00100D1F,
      32'h02100D1F, 32'h02100D1F, 32'h020C0C1F, 32'h020F0D1F, 32'h020F0F1F,
      32'h02110C1F, 32'h02110D1F, 32'h0211181F, 32'h0200181F, 32'h0200181F,
      32'h02001800, 32'h02001800, 32'h00001800, 32'h01001800};
   seh_if link ();
   seh_host seh_host_inst (.CLK(CLK), .RST_B(RST_B), .LINK(link.host),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_DAT_I(dw), .WB_SEL_I(4'hF), .WB_DAT_O(dr), .WB_ACK_O(ack),
      .BUSY(busy));
   seh_device #(.QUIET_CYC(50)) seh_device_inst (.CLK(CLK), .RST_B(RST_B),
      .LINK(link.dev), .PCM_DIN(pin), .DSP_DOUT(1'b0), .SAMPLE(smp),
      .SAMPLE_VALID(sv), .PCM_DOUT(dout), .DSP_HALT(halt), .MODE_EQ(meq),
      .LEVEL(lvl), .BAND_GAIN(band), .FILT_GAIN(filt), .NOISE_THR(thr),
      .INPUT_ZERO(izero), .STATUS(stat));
   seh_chk seh_chk_inst (.CLK(CLK), .RST_B(RST_B), .scl_oe(link.scl_oe),
      .h_sda_oe(link.h_sda_oe), .d_sda_oe(link.d_sda_oe),
      .scl(link.scl), .sda(link.sda));
   // --------
   // helpers
   // --------
   function automatic logic [31:0] snap();
      return {stat, 3'h0, band[0], 3'h0, band[3], thr};
   endfunction : snap
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk
   task automatic finish_test();
      if (errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   // request held until ack is sampled
   task automatic wb(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge CLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= wr;
      adr <= a;
      dw  <= d;
      do @(posedge CLK); while (ack !== 1'b1);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic cmd(input logic [31:0] c);
      wb(1'b1, `SEH_REG_CMD, c);
      do wb(1'b0, `SEH_REG_STAT, 32'h0); while (q[0] !== 1'b0);
   endtask : cmd
   task automatic rd(input logic [7:0] x);
      cmd(32'h20000);
      chk({23'h0, q[15:8], q[1]}, {23'h0, x, 1'b0});
   endtask : rd
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   initial begin
      #2400000;
      errors++;
      finish_test();
   end
   initial begin
      {RST_B, cyc, stb, we, adr, dw} = '0;
      smp = 16'h0100;
      pin = 1'b1;
      sv = 1'b1;
      repeat (16) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (4) @(posedge CLK);
      chk(snap(), 32'h05100D1F);
      chk({28'h0, lvl, meq, dout}, 32'h5);
      for (int i = 0; i < 17; i++) begin
         cmd(w[i]);
         chk(snap(), e[i]);
         chk({28'h0, lvl, meq, dout}, {28'h0, e[i][27:24]});
      end
      chk({31'h0, halt}, 32'h1);
      cmd(32'h1930B);
      cmd(32'h19D0B);
      chk({28'h0, filt[9]}, 32'h3);
      cmd(32'h1010E);
      rd(8'h01);
      cmd(32'h1050E);
      rd(8'h18);
      cmd(32'h15A0C);
      rd(8'h5A);
      rd(8'h5A);
      // second write lands while busy and is dropped
      wb(1'b1, `SEH_REG_CMD, 32'h1330D);
      @(posedge CLK);
      chk({31'h0, busy}, 32'h1);
      cmd(32'h1440D);
      chk({24'h0, thr}, 32'h33);
      sv <= 1'b0;
      repeat (60) @(posedge CLK);
      chk({31'h0, izero}, 32'h1);
      sv <= 1'b1;
      repeat (3) @(posedge CLK);
      chk({31'h0, izero}, 32'h0);
      RST_B <= 1'b0;
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (4) @(posedge CLK);
      chk(snap(), 32'h05100D1F);
      chk({28'h0, lvl, meq, dout}, 32'h5);
      finish_test();
   end
endmodule : testbench
`default_nettype wire
